// ### verilog/tdm_pkg.sv
`default_nettype none
package tdm_pkg;
  // ---------------------------------------------------------------
  // Stream framing.
  // ---------------------------------------------------------------
  localparam int unsigned SLOT_BITS      = 8;
  localparam int unsigned SLOTS_PER_FRM  = 32;
  localparam int unsigned SLOT_W         = 5;
  localparam int unsigned BIT_W          = 3;
  localparam int unsigned CNT_W          = 8;
  localparam int unsigned STREAM_KBPS    = 2048;
  localparam int unsigned FRAME_US       = 125;
  localparam int unsigned RESET_MIN_NS   = 1000;
  localparam int unsigned CLK_SYS_NS     = 25;
  localparam int unsigned RESET_MIN_CYC  = (RESET_MIN_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
  // ---------------------------------------------------------------
  // Timeslot map.
  // ---------------------------------------------------------------
  localparam logic [4:0] SLOT_ALIGN      = 5'h00;
  localparam logic [4:0] SLOT_E1_SIGMF   = 5'h10;
  localparam logic [4:0] SLOT_T1_LAST    = 5'h18;
  localparam logic [2:0] BIT_LAST        = 3'h7;
  localparam logic [2:0] BIT_UPPER_LAST  = 3'h3;
  localparam logic [4:0] SLOT_FIRST_CH   = 5'h01;
  localparam logic [7:0] CNT_RESET       = 8'h00;
  localparam logic [7:0] NIBBLE_FILL     = 8'h00;
endpackage
`default_nettype wire

// ### verilog/tdm_timing_if.sv
`default_nettype none
interface tdm_timing_if;
  logic       fall_tick;
  logic       rise_tick;
  logic [4:0] slot;
  logic [2:0] bit_idx;
  logic       data_in;
  logic       sig_in;
  modport source (output fall_tick, rise_tick, slot, bit_idx, data_in, sig_in);
  modport sink   (input  fall_tick, rise_tick, slot, bit_idx, data_in, sig_in);
endinterface
`default_nettype wire

// ### verilog/tdm_stream_timing.sv
`default_nettype none
module tdm_stream_timing (
  input  wire logic  clk_sys,
  input  wire logic  srst,
  input  wire logic  bit_clk,
  input  wire logic  frame_sync_n,
  input  wire logic  channel_data_in,
  input  wire logic  signaling_control_in,
  tdm_timing_if.source tim
);
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic       clk_prev;
    logic       frm_seen;
    logic [7:0] cnt;
    logic       fall;
    logic       rise;
  } tstate_t;

  tstate_t q;
  tstate_t d;

  // ---------------------------------------------------------------
  // Pin sampling, edge finding and bit counting.
  // ---------------------------------------------------------------
  always_comb begin
    d      = q;
    d.s1   = {bit_clk, frame_sync_n, channel_data_in, signaling_control_in};
    d.s2   = q.s1;
    d.clk_prev = q.s2[3];
    d.fall = 1'b0;
    d.rise = 1'b0;
    if (q.clk_prev && !q.s2[3]) begin
      d.fall = 1'b1;
      d.cnt  = q.frm_seen ? tdm_pkg::CNT_RESET : 8'(q.cnt + 8'h01);
      d.frm_seen = 1'b0;
    end
    if (!q.clk_prev && q.s2[3]) begin
      d.rise = 1'b1;
      d.frm_seen = !q.s2[2];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      // Sampled pins reset to their idle high level so no false edge follows reset.
      q <= '{s1: 4'hf, s2: 4'hf, clk_prev: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign tim.fall_tick = q.fall;
  assign tim.rise_tick = q.rise;
  assign tim.slot      = q.cnt[7:3];
  assign tim.bit_idx   = q.cnt[2:0];
  assign tim.data_in   = q.s2[1];
  assign tim.sig_in    = q.s2[0];
endmodule
`default_nettype wire

// ### verilog/tdm_system_stream_port.sv
`default_nettype none
module tdm_system_stream_port (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       bit_clk,
  input  wire logic       frame_sync_n,
  input  wire logic       channel_data_in,
  input  wire logic       signaling_control_in,
  input  wire logic       nibble_position_select,
  input  wire logic       tx_signaling_source_select,
  input  wire logic       t1_mode,
  input  wire logic [7:0] line_rx_byte,
  input  wire logic [3:0] line_rx_sig,
  output logic            channel_data_out,
  output logic            channel_data_oe,
  output logic            signaling_status_out,
  output logic            signaling_status_oe,
  output logic [4:0]      line_slot,
  output logic [7:0]      tx_byte,
  output logic [4:0]      tx_byte_slot,
  output logic            tx_byte_valid,
  output logic [3:0]      tx_sig,
  output logic [4:0]      tx_sig_slot,
  output logic            tx_sig_valid
);
  typedef struct packed {
    logic [7:0] dsh;
    logic [7:0] ssh;
    logic       dout;
    logic       doe;
    logic       sout;
    logic       soe;
    logic [4:0] lslot;
    logic [7:0] din;
    logic [7:0] sin;
    logic [7:0] txb;
    logic [4:0] txb_slot;
    logic       txb_vld;
    logic [3:0] txs;
    logic [4:0] txs_slot;
    logic       txs_vld;
  } pstate_t;

  pstate_t q;
  pstate_t d;

  tdm_timing_if tim ();

  tdm_stream_timing u_timing (
    .clk_sys              (clk_sys),
    .srst                 (srst),
    .bit_clk              (bit_clk),
    .frame_sync_n         (frame_sync_n),
    .channel_data_in      (channel_data_in),
    .signaling_control_in (signaling_control_in),
    .tim                  (tim.source)
  );

  // ---------------------------------------------------------------
  // Timeslot classification.
  // ---------------------------------------------------------------
  function automatic logic sig_slot(input logic [4:0] s);
    sig_slot = (s != tdm_pkg::SLOT_ALIGN) && (s != tdm_pkg::SLOT_E1_SIGMF);
  endfunction

  function automatic logic data_slot(input logic [4:0] s, input logic t1);
    if (t1) begin
      data_slot = (s >= tdm_pkg::SLOT_FIRST_CH) && (s <= tdm_pkg::SLOT_T1_LAST);
    end else begin
      data_slot = sig_slot(s);
    end
  endfunction

  logic       upper_half;
  logic       nib_active;
  logic [7:0] din_full;
  logic [7:0] sin_full;

  always_comb begin
    upper_half = (tim.bit_idx <= tdm_pkg::BIT_UPPER_LAST);
    nib_active = (nibble_position_select == upper_half);
    din_full   = {q.din[6:0], tim.data_in};
    sin_full   = {q.sin[6:0], tim.sig_in};
  end

  // ---------------------------------------------------------------
  // Stream engine.
  // ---------------------------------------------------------------
  always_comb begin
    d         = q;
    d.txb_vld = 1'b0;
    d.txs_vld = 1'b0;
    if (tim.fall_tick) begin
      if (tim.bit_idx == 3'h0) begin
        d.dsh   = line_rx_byte;
        d.ssh   = nibble_position_select ? {line_rx_sig, 4'h0} : {4'h0, line_rx_sig};
        d.lslot = 5'(tim.slot + 5'h01);
      end else begin
        d.dsh = {q.dsh[6:0], 1'b0};
        d.ssh = {q.ssh[6:0], 1'b0};
      end
      d.dout = d.dsh[7];
      d.doe  = data_slot(tim.slot, t1_mode);
      d.sout = d.ssh[7];
      d.soe  = sig_slot(tim.slot) && nib_active;
    end
    if (tim.rise_tick) begin
      d.din = din_full;
      d.sin = sin_full;
      if (tim.bit_idx == tdm_pkg::BIT_LAST) begin
        if (data_slot(tim.slot, t1_mode)) begin
          d.txb      = din_full;
          d.txb_slot = tim.slot;
          d.txb_vld  = 1'b1;
        end
        if (!tx_signaling_source_select && sig_slot(tim.slot)) begin
          d.txs      = nibble_position_select ? sin_full[7:4] : sin_full[3:0];
          d.txs_slot = tim.slot;
          d.txs_vld  = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign channel_data_out     = q.dout;
  assign channel_data_oe      = q.doe;
  assign signaling_status_out = q.sout;
  assign signaling_status_oe  = q.soe;
  assign line_slot            = q.lslot;
  assign tx_byte              = q.txb;
  assign tx_byte_slot         = q.txb_slot;
  assign tx_byte_valid        = q.txb_vld;
  assign tx_sig               = q.txs;
  assign tx_sig_slot          = q.txs_slot;
  assign tx_sig_valid         = q.txs_vld;
endmodule
`default_nettype wire

// ### sim/tdm_system_stream_port_asserts.sv
`default_nettype none
module tdm_port_checker (
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic       nibble_position_select,
  input wire logic       tx_signaling_source_select,
  input wire logic       t1_mode,
  input wire logic       channel_data_oe,
  input wire logic       signaling_status_oe,
  input wire logic [4:0] line_slot,
  input wire logic [4:0] tx_byte_slot,
  input wire logic       tx_byte_valid,
  input wire logic [4:0] tx_sig_slot,
  input wire logic       tx_sig_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------
  // Slot timing checks.
  // ------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence slot_start; $changed(line_slot); endsequence
  sequence mid_slot; !$changed(line_slot); endsequence
  status_slot_a: assert property (
    signaling_status_oe |-> !(line_slot inside {5'h01, 5'h11})) else $error("status slot");
  data_slot_a: assert property (channel_data_oe |-> (t1_mode ?
    line_slot inside {[5'h02:5'h19]} : !(line_slot inside {5'h01, 5'h11})))
    else $error("data slot");
  upper_nibble_a: assert property (
    $rose(signaling_status_oe) && nibble_position_select |-> slot_start) else $error("upper");
  lower_nibble_a: assert property (
    $rose(signaling_status_oe) && !nibble_position_select |-> mid_slot) else $error("lower");
  ctrl_ignored_a: assert property (tx_signaling_source_select |-> !tx_sig_valid)
    else $error("ignored stream used");
  sig_pulse_a: assert property (tx_sig_valid |-> !(tx_sig_slot inside {5'h00, 5'h10})
    ##1 !tx_sig_valid) else $error("sig pulse");
  byte_pulse_a: assert property (tx_byte_valid |=> !tx_byte_valid)
    else $error("byte pulse");
  byte_slot_a: assert property (tx_byte_valid |-> line_slot == tx_byte_slot + 5'h01)
    else $error("byte slot");
endmodule
bind tdm_system_stream_port tdm_port_checker tdm_port_checker_i (.clk_sys, .srst,
  .nibble_position_select, .tx_signaling_source_select, .t1_mode, .channel_data_oe,
  .signaling_status_oe, .line_slot, .tx_byte_slot, .tx_byte_valid, .tx_sig_slot, .tx_sig_valid);
`default_nettype wire

// ### sim/tdm_backplane_model.sv
`default_nettype none
module tdm_backplane_model (
  output logic            bit_clk,
  output logic            frame_sync_n,
  output logic            channel_data_in,
  output logic            signaling_control_in,
  input  wire logic [7:0] data_byte,
  input  wire logic [7:0] ctrl_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] bit_n;
  // ------------------------------------------------
  // Free bit clock, bits launched on falling edges.
  // ------------------------------------------------
  initial begin
    {bit_clk, frame_sync_n, channel_data_in, signaling_control_in} = 4'hf;
    bit_n = 8'hff;
    #13;
    forever begin
      #100 bit_clk = 1'b0;
      bit_n = bit_n + 8'h01;
      frame_sync_n = (bit_n != 8'hff);
      channel_data_in = data_byte[3'h7 - bit_n[2:0]];
      signaling_control_in = ctrl_byte[3'h7 - bit_n[2:0]];
      #100 bit_clk = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### sim/tdm_system_stream_port_tb.sv
`default_nettype none
module tdm_system_stream_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0, srst = 1'b1, t1_mode = 1'b0;
  logic nibble_position_select = 1'b1, tx_signaling_source_select = 1'b0;
  logic [7:0] line_rx_byte = 8'hb4, data_byte = 8'h5a, ctrl_byte = 8'hc3, dsr, ssr;
  logic [3:0] line_rx_sig = 4'h9, tx_sig;
  logic [4:0] line_slot, tx_byte_slot, tx_sig_slot;
  logic [7:0] tx_byte;
  logic bit_clk, frame_sync_n, channel_data_in, signaling_control_in, tx_byte_valid;
  logic channel_data_out, channel_data_oe, signaling_status_out, signaling_status_oe;
  logic tx_sig_valid;
  int fail_count = 0, checks = 0;
  tdm_backplane_model tdm_backplane_model_i (.bit_clk, .frame_sync_n, .channel_data_in,
    .signaling_control_in, .data_byte, .ctrl_byte);
  tdm_system_stream_port tdm_system_stream_port_i (.clk_sys, .srst, .bit_clk, .frame_sync_n,
    .channel_data_in, .signaling_control_in, .nibble_position_select, .t1_mode,
    .tx_signaling_source_select, .line_rx_byte, .line_rx_sig, .channel_data_out,
    .channel_data_oe, .signaling_status_out, .signaling_status_oe, .line_slot, .tx_byte,
    .tx_byte_slot, .tx_byte_valid, .tx_sig, .tx_sig_slot, .tx_sig_valid);
  // ------------------------------------------------
  // Clock, stream capture and shared tasks.
  // ------------------------------------------------
  initial forever #12.5 clk_sys = ~clk_sys;
  always @(negedge bit_clk) begin
    if (channel_data_oe) dsr <= {dsr[6:0], channel_data_out};
    if (signaling_status_oe) ssr <= {ssr[6:0], signaling_status_out};
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_slot(input logic [4:0] s);
    for (int n = 0; n < 3000 && line_slot === s; n++) @(posedge clk_sys);
    for (int n = 0; n < 3000 && line_slot !== s; n++) @(posedge clk_sys);
  endtask
  task automatic stream_case(input logic t1m, input logic sel, input logic src);
    logic seen;
    @(posedge clk_sys);
    srst <= 1'b1;
    t1_mode <= t1m;
    nibble_position_select <= sel;
    tx_signaling_source_select <= src;
    repeat (tdm_pkg::RESET_MIN_CYC) @(posedge clk_sys);
    srst <= 1'b0;
    wait_slot(5'h06);
    wait_slot(5'h06);
    chk(dsr, line_rx_byte);
    chk(ssr, {line_rx_sig, line_rx_sig});
    seen = 1'b0;
    for (int n = 0; n < 2100; n++) begin
      @(posedge clk_sys);
      if (tx_byte_valid === 1'b1 && tx_byte_slot === 5'h07) chk(tx_byte, data_byte);
      if (tx_sig_valid === 1'b1) begin
        seen = 1'b1;
        chk({4'h0, tx_sig}, {4'h0, sel ? ctrl_byte[7:4] : ctrl_byte[3:0]});
      end
    end
    chk({7'h0, seen}, {7'h0, !src});
    $display("Case t1=%0b sel=%0b src=%0b done", t1m, sel, src);
  endtask
  task automatic e1_upper; stream_case(1'b0, 1'b1, 1'b0); endtask
  task automatic e1_lower; stream_case(1'b0, 1'b0, 1'b0); endtask
  task automatic e1_ignore; stream_case(1'b0, 1'b1, 1'b1); endtask
  task automatic t1_upper; stream_case(1'b1, 1'b1, 1'b0); endtask
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ------------------------------------------------
  // Main sequence and watchdog.
  // ------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    e1_upper();
    e1_lower();
    e1_ignore();
    t1_upper();
    conclude();
  end
  initial begin
    #1500000;
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
